// ===== rtl/llc_map.svh
// offsets, field positions, reset values and counts of the line lock block
`ifndef LLC_MAP_SVH
`define LLC_MAP_SVH

`define LLC_ADDR_W 8
`define LLC_OFF_REARM 8'h00
`define LLC_OFF_CTRL 8'h04
`define LLC_OFF_STATUS 8'h08
`define LLC_OFF_LOOP 8'h0C

`define LLC_CTRL_W 8
`define LLC_CTRL_RESET 8'h40

`define LLC_ST_COINCIDENCE 0
`define LLC_ST_VIDEO 1
`define LLC_ST_CAL_SWITCH 2
`define LLC_ST_CAL_HOLD 3
`define LLC_ST_DAC_LSB 8

`define LLC_DIV_RATIO 64
`define LLC_LOCK_LINES 4'h8
`define LLC_NOSYNC_LINES 4'h4
`define LLC_CAL_LINE_A 10'h004
`define LLC_CAL_LINE_B 10'h005
`define LLC_FIELD_FIRST 10'h001

`define LLC_BURST_START 6'h06
`define LLC_BURST_END 6'h0A
`define LLC_BLANK_END 6'h0C
`define LLC_SQUARE_HALF 6'h20
`define LLC_LOCK_WIN 10'h020

`define LLC_DAC_MID 8'h80
`define LLC_DAC_SHIFT 6
`define LLC_PD_SHIFT_BASE 4
`endif

// ===== rtl/llc_pkg.sv
// types shared by the line lock block
package llc_pkg;

    // control byte, bit 0 first from the right
    typedef struct packed {
        logic yuv_sel;
        logic continuous;
        logic periodic_off;
        logic xtal_14m3;
        logic gate_disable;
        logic gain_high;
        logic filter_long;
        logic line_out_sel;
    } llc_ctrl_t;

    // line-rate output group
    typedef struct packed {
        logic line_rate_square_out;
        logic burst_gate;
        logic [1:0] sandcastle_level;
        logic line_x16_or_composite_sync_out;
    } llc_line_outs_t;

    typedef logic signed [15:0] llc_offset_t;
    typedef logic signed [9:0] llc_phase_t;

endpackage : llc_pkg

// ===== rtl/llc_sync3.sv
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/10ps
`default_nettype none
module llc_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pins and clean copy
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] clean_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // per bit: a change counts only once stage two and three agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clean_out <= INIT;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    clean_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : llc_sync3
`default_nettype wire

// ===== rtl/llc_freq_cal.sv
// calibration loop: line period comparator and up/down dac counter
`timescale 1ns/10ps
`default_nettype none
`include "llc_map.svh"
module llc_freq_cal #(
    parameter int CNT_W = 14,
    parameter logic [CNT_W-1:0] REF_14M3 = 14'd6356,
    parameter logic [CNT_W-1:0] REF_17M7 = 14'd6400
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // loop side
    input wire logic line_tick,
    input wire logic xtal_14m3,
    input wire logic cal_engaged,
    output logic [7:0] dac_q
);
    logic [CNT_W-1:0] len_q;
    logic [CNT_W-1:0] ref_len;

    // divided crystal reference expressed as a line length
    assign ref_len = xtal_14m3 ? REF_14M3 : REF_17M7;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            len_q <= '0;
        end else if (line_tick) begin
            // the tick cycle itself belongs to the new line
            len_q <= CNT_W'(1);
        end else if (len_q != '1) begin
            len_q <= len_q + 1'b1;
        end
    end

    // only steps while the switch closes the loop; otherwise it would chase
    // the phase loop and lose the stored rate
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dac_q <= `LLC_DAC_MID;
        end else if (line_tick && cal_engaged) begin
            if (len_q < ref_len && dac_q != 8'h00) begin
                dac_q <= dac_q - 8'h01;
            end else if (len_q > ref_len && dac_q != 8'hFF) begin
                dac_q <= dac_q + 8'h01;
            end
        end
    end
endmodule : llc_freq_cal
`default_nettype wire

// ===== rtl/llc_line_lock.sv
// horizontal line lock loop with calibration and line-rate outputs
`timescale 1ns/10ps
`default_nettype none
`include "llc_map.svh"
module llc_line_lock #(
    parameter int WORD_W = 24,
    parameter logic [WORD_W-1:0] NOM_WORD = 24'd167772,
    parameter logic [13:0] REF_14M3 = 14'd6356,
    parameter logic [13:0] REF_17M7 = 14'd6400
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register port
    input wire logic [`LLC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // pins from the sync separator
    input wire logic csync_n_pin,
    input wire logic vert_interval_pin,
    // line-rate outputs
    output llc_pkg::llc_line_outs_t line_outs,
    // analog switch controls
    output logic filter_switch_close,
    output logic calibration_path_switch,
    output logic [2:0] sync_on_output,
    // oscillator state
    output logic [WORD_W-1:0] osc_word,
    output logic coincidence
);
    logic rst_m_q;
    logic rst_n_q;
    llc_pkg::llc_ctrl_t ctrl_q;
    logic cal_hold_q;
    logic cont_eff;
    logic [WORD_W-1:0] acc_q;
    logic [WORD_W:0] acc_sum;
    logic [5:0] div_q;
    logic osc_tick;
    logic line_tick;
    logic csync_s;
    logic vert_s;
    logic csync_prev_q;
    logic vert_prev_q;
    logic sync_edge;
    logic gate_on;
    llc_pkg::llc_phase_t phase_err;
    llc_pkg::llc_offset_t pd_off_q;
    llc_pkg::llc_offset_t pd_step;
    logic [3:0] pd_shift;
    logic [9:0] field_line_q;
    logic [3:0] idle_lines_q;
    logic [3:0] lock_run_q;
    logic edge_seen_q;
    logic video_present;
    logic cal_sw;
    logic [7:0] dac_val;
    logic in_window;

    // offset from nominal oscillator word, clamped at zero below, truncated to the word width above
    function automatic logic [WORD_W-1:0] word_of(
        input llc_pkg::llc_offset_t off);
        logic signed [WORD_W+1:0] w;
        w = $signed({2'b00, NOM_WORD}) + (WORD_W + 2)'(off);
        if (w < 0) begin
            word_of = '0;
        end else begin
            word_of = w[WORD_W-1:0];
        end
    endfunction : word_of

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    llc_sync3 #(
        .W(2),
        .INIT(2'b11)
    ) u_pins (
        .clk_sys(clk_sys),
        .rst_n(rst_n_q),
        .pin_in({csync_n_pin, vert_interval_pin}),
        .clean_out({csync_s, vert_s})
    );

    // control register
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= `LLC_CTRL_RESET;
        end else if (reg_wr && reg_addr == `LLC_OFF_CTRL) begin
            ctrl_q <= reg_wdata[`LLC_CTRL_W-1:0];
        end
    end

    // power-up hold: freed only by a zero write while the bit is clear
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cal_hold_q <= 1'b1;
        end else if (reg_wr && reg_addr == `LLC_OFF_REARM &&
                     reg_wdata == 32'h0000_0000 && !ctrl_q.continuous) begin
            cal_hold_q <= 1'b0;
        end
    end

    assign cont_eff = ctrl_q.continuous | cal_hold_q;

    // digital oscillator at 64 times line rate
    assign acc_sum = {1'b0, acc_q} + {1'b0, osc_word};
    assign osc_tick = acc_sum[WORD_W];
    assign line_tick = osc_tick && (div_q == 6'(`LLC_DIV_RATIO - 1));

    // runs unconditionally: no video or vertical term may stop it
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            acc_q <= '0;
            div_q <= 6'h00;
        end else begin
            acc_q <= acc_sum[WORD_W-1:0];
            if (osc_tick) begin
                div_q <= div_q + 6'h01;
            end
        end
    end

    // edges and vertical gating
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            csync_prev_q <= 1'b1;
            vert_prev_q <= 1'b1;
        end else begin
            csync_prev_q <= csync_s;
            vert_prev_q <= vert_s;
        end
    end

    assign gate_on = !ctrl_q.gate_disable && !ctrl_q.gain_high && vert_s;
    assign sync_edge = csync_prev_q && !csync_s;

    // sync leading edge expected at divider phase zero
    assign phase_err = $signed({div_q, acc_q[WORD_W-1 -: 4]});
    assign in_window = (phase_err < $signed(`LLC_LOCK_WIN)) &&
                       (phase_err > -$signed(`LLC_LOCK_WIN));

    // high gain enlarges the step, long filter lengthens the time constant
    always_comb begin
        pd_shift = 4'(`LLC_PD_SHIFT_BASE);
        if (ctrl_q.gain_high) begin
            pd_shift = pd_shift - 4'h2;
        end
        if (ctrl_q.filter_long) begin
            pd_shift = pd_shift + 4'h2;
        end
        pd_step = 16'(phase_err) >>> pd_shift;
    end

    // phase detector integrator, loaded with the dac offset while the dac owns the oscillator
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pd_off_q <= 16'h0000;
        end else if (cal_sw) begin
            pd_off_q <= 16'($signed({1'b0, dac_val}) - 9'sh080) <<<
                        `LLC_DAC_SHIFT;
        end else if (sync_edge && !gate_on) begin
            pd_off_q <= pd_off_q - pd_step;
        end
    end

    // field line count, line one starts with the vertical interval
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            field_line_q <= 10'h000;
        end else if (vert_s && !vert_prev_q) begin
            field_line_q <= `LLC_FIELD_FIRST;
        end else if (line_tick && field_line_q != 10'h3FF) begin
            field_line_q <= field_line_q + 10'h001;
        end
    end

    // video presence from sync edges within the last few lines
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            idle_lines_q <= `LLC_NOSYNC_LINES;
        end else if (sync_edge) begin
            idle_lines_q <= 4'h0;
        end else if (line_tick && idle_lines_q != `LLC_NOSYNC_LINES) begin
            idle_lines_q <= idle_lines_q + 4'h1;
        end
    end

    assign video_present = idle_lines_q != `LLC_NOSYNC_LINES;

    // coincidence: consecutive lines with an edge inside the window
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lock_run_q <= 4'h0;
            edge_seen_q <= 1'b0;
        end else if (cont_eff) begin
            lock_run_q <= 4'h0;
            edge_seen_q <= 1'b0;
        end else if (sync_edge && !gate_on) begin
            edge_seen_q <= 1'b1;
            if (!in_window) begin
                lock_run_q <= 4'h0;
            end else if (lock_run_q != `LLC_LOCK_LINES) begin
                lock_run_q <= lock_run_q + 4'h1;
            end
        end else if (line_tick) begin
            edge_seen_q <= 1'b0;
            if (!edge_seen_q && !gate_on) begin
                lock_run_q <= 4'h0;
            end
        end
    end

    // calibration switch position
    always_comb begin
        cal_sw = cont_eff;
        if (!ctrl_q.periodic_off &&
            (field_line_q == `LLC_CAL_LINE_A ||
             field_line_q == `LLC_CAL_LINE_B)) begin
            cal_sw = 1'b1;
        end
    end

    llc_freq_cal #(
        .CNT_W(14),
        .REF_14M3(REF_14M3),
        .REF_17M7(REF_17M7)
    ) u_cal (
        .clk_sys(clk_sys),
        .rst_n(rst_n_q),
        .line_tick(line_tick),
        .xtal_14m3(ctrl_q.xtal_14m3),
        .cal_engaged(cal_sw),
        .dac_q(dac_val)
    );

    // oscillator word: dac through the switch, else the phase detector
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            osc_word <= NOM_WORD;
        end else if (cal_sw) begin
            // signed offset: a dac below mid must slow the oscillator
            osc_word <= word_of(16'($signed({1'b0, dac_val}) - 9'sh080) <<<
                                `LLC_DAC_SHIFT);
        end else begin
            osc_word <= word_of(pd_off_q);
        end
    end

    // line-rate outputs decoded from the divider phase, the composite sync choice from csync_s while video is present, else held high
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            line_outs <= '0;
            line_outs.line_x16_or_composite_sync_out <= 1'b1;
        end else begin
            line_outs.line_rate_square_out <= div_q < `LLC_SQUARE_HALF;
            line_outs.burst_gate <= div_q >= `LLC_BURST_START &&
                                    div_q < `LLC_BURST_END;
            if (div_q >= `LLC_BURST_START && div_q < `LLC_BURST_END) begin
                line_outs.sandcastle_level <= 2'h2;
            end else if (div_q < `LLC_BLANK_END) begin
                line_outs.sandcastle_level <= 2'h1;
            end else begin
                line_outs.sandcastle_level <= 2'h0;
            end
            if (!ctrl_q.line_out_sel) begin
                line_outs.line_x16_or_composite_sync_out <= div_q[1];
            end else if (!video_present) begin
                line_outs.line_x16_or_composite_sync_out <= 1'b1;
            end else begin
                line_outs.line_x16_or_composite_sync_out <= csync_s;
            end
        end
    end

    // switch controls and status flops
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            filter_switch_close <= 1'b0;
            calibration_path_switch <= 1'b1;
            sync_on_output <= 3'h7;
            coincidence <= 1'b0;
        end else begin
            filter_switch_close <= ctrl_q.filter_long;
            calibration_path_switch <= cal_sw;
            sync_on_output <= ctrl_q.yuv_sel ? 3'h2 : 3'h7;
            coincidence <= !cont_eff &&
                           lock_run_q == `LLC_LOCK_LINES;
        end
    end

    // read port, data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `LLC_OFF_CTRL: begin
                    reg_rdata <= {24'h000000, ctrl_q};
                end
                `LLC_OFF_STATUS: begin
                    reg_rdata <= 32'h0000_0000;
                    reg_rdata[`LLC_ST_COINCIDENCE] <= coincidence;
                    reg_rdata[`LLC_ST_VIDEO] <= video_present;
                    reg_rdata[`LLC_ST_CAL_SWITCH] <= cal_sw;
                    reg_rdata[`LLC_ST_CAL_HOLD] <= cal_hold_q;
                    reg_rdata[`LLC_ST_DAC_LSB +: 8] <= dac_val;
                end
                `LLC_OFF_LOOP: begin
                    reg_rdata <= {16'h0000, pd_off_q};
                end
                default: begin
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule : llc_line_lock
`default_nettype wire

// ===== testbench/llc_line_lock_checker.sv
// concurrent checks on the ports of the line lock block
`timescale 1ns/10ps
`default_nettype none
`include "llc_map.svh"
module llc_line_lock_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register port
    input wire logic [`LLC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // outputs
    input wire llc_pkg::llc_line_outs_t line_outs,
    input wire logic filter_switch_close,
    input wire logic calibration_path_switch,
    input wire logic [2:0] sync_on_output,
    input wire logic coincidence
);
    logic ctrl_wr;
    logic sel_q;
    logic per_q;
    logic cont_q;
    logic hold_q;
    logic eff;
    logic quiet;
    assign ctrl_wr = reg_wr && reg_addr == `LLC_OFF_CTRL;
    assign eff = cont_q | hold_q;
    assign quiet = !eff && per_q;
    // shadow of the control bits the checks depend on
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sel_q <= 1'b0;
            per_q <= 1'b0;
            cont_q <= 1'b1;
        end else if (ctrl_wr) begin
            sel_q <= reg_wdata[0];
            per_q <= reg_wdata[5];
            cont_q <= reg_wdata[6];
        end
    end
    // re-arm only counts once continuous is already off
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= 1'b1;
        end else if (reg_wr && reg_addr == `LLC_OFF_REARM && !cont_q) begin
            hold_q <= hold_q && reg_wdata != 32'h0;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_filter_follow: assert property (
        ctrl_wr |-> ##3 filter_switch_close == $past(reg_wdata[1], 3))
        else $error("filter switch does not follow control");
    a_sync_mode: assert property (
        ctrl_wr |-> ##3 sync_on_output == ($past(reg_wdata[7], 3) ? 3'h2 : 3'h7))
        else $error("sync output set wrong");
    a_x16_phase: assert property (
        $rose(line_outs.burst_gate) && !sel_q
        |-> line_outs.line_x16_or_composite_sync_out)
        else $error("x16 output out of phase");
    a_burst_square: assert property (
        $rose(line_outs.burst_gate) |-> $past(line_outs.line_rate_square_out))
        else $error("burst gate outside square high half");
    a_burst_key: assert property (
        line_outs.burst_gate == (line_outs.sandcastle_level == 2'h2))
        else $error("sandcastle and burst disagree");
    a_cont_no_lock: assert property (
        eff && $past(eff, 3) |-> !coincidence)
        else $error("lock flag set in continuous calibration");
    a_cont_switch: assert property (
        eff && $past(eff, 3) |-> calibration_path_switch)
        else $error("calibration path open in continuous mode");
    a_periodic_off: assert property (
        quiet && $past(quiet, 3) |-> !calibration_path_switch)
        else $error("recalibration while periodic is off");
endmodule : llc_line_lock_checker

bind llc_line_lock llc_line_lock_checker u_checker (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .line_outs(line_outs),
    .filter_switch_close(filter_switch_close),
    .calibration_path_switch(calibration_path_switch),
    .sync_on_output(sync_on_output),
    .coincidence(coincidence)
);
`default_nettype wire

// ===== testbench/llc_sync_source.sv
// composite sync source model with vertical interval
`timescale 1ns/10ps
`default_nettype none
module llc_sync_source #(
    parameter int LINE = 640,
    parameter int FIELD = 10
) (
    // clock
    input wire logic clk_sys,
    // video present
    input wire logic active,
    // sync pins
    output logic csync_n_pin = 1'b1,
    output logic vert_interval_pin = 1'b0
);
    int pos = 0;
    int line = 0;
    always @(posedge clk_sys) begin
        pos <= (pos == LINE - 1) ? 0 : pos + 1;
        if (pos == LINE - 1) begin
            line <= (line == FIELD - 1) ? 0 : line + 1;
        end
        // half-line pulses in the vertical interval disturb an ungated loop
        csync_n_pin <= !active || !(pos < 48 ||
            (line < 3 && pos >= LINE / 2 && pos < LINE / 2 + 24));
        vert_interval_pin <= active && line < 3;
    end
endmodule : llc_sync_source
`default_nettype wire

// ===== testbench/test_llc_line_lock.sv
// self-checking bench for the line lock block
`timescale 1ns/10ps
`default_nettype none
`include "llc_map.svh"
module test_llc_line_lock;
    localparam int LINE = 640;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic active = 1'b1;
    logic [31:0] reg_rdata;
    wire logic csync_n_pin;
    wire logic vert_interval_pin;
    llc_pkg::llc_line_outs_t line_outs;
    logic filter_switch_close;
    logic calibration_path_switch;
    logic [2:0] sync_on_output;
    logic [23:0] osc_word;
    logic coincidence;
    int bad_count = 0;
    int check_count = 0;
    int x16_rises = 0;
    int sq_rises = 0;
    int n;
    logic [31:0] d;

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge line_outs.line_x16_or_composite_sync_out) x16_rises++;
    always @(posedge line_outs.line_rate_square_out) sq_rises++;

    llc_sync_source #(.LINE(LINE), .FIELD(10)) u_src (
        .clk_sys(clk_sys),
        .active(active),
        .csync_n_pin(csync_n_pin),
        .vert_interval_pin(vert_interval_pin)
    );
    // shortened oscillator: one line is LINE clocks
    llc_line_lock #(
        .NOM_WORD(24'd1677720),
        .REF_14M3(14'd636),
        .REF_17M7(14'd640)
    ) dut (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .csync_n_pin(csync_n_pin),
        .vert_interval_pin(vert_interval_pin),
        .line_outs(line_outs),
        .filter_switch_close(filter_switch_close),
        .calibration_path_switch(calibration_path_switch),
        .sync_on_output(sync_on_output),
        .osc_word(osc_word),
        .coincidence(coincidence)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read
    // cycles spent until the switch leaves its opposite level
    task automatic wait_sw(input logic lvl, input int lim, output int k);
        k = 0;
        while ((calibration_path_switch === lvl) == 0 && k < lim) begin
            @(posedge clk_sys);
            k++;
        end
    endtask : wait_sw
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (90000) @(posedge clk_sys);
        bad_count++;
        $display("unexpected at %0t: run too long", $time);
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reg_read(`LLC_OFF_CTRL);
        check(d, 32'h40);
        reg_read(`LLC_OFF_STATUS);
        check({d[3], d[0]}, 32'h2);
        reg_write(8'h10, 32'hFF);
        reg_read(8'h10);
        check(d, 32'h0);
        reg_read(`LLC_OFF_REARM);
        check(d, 32'h0);
        check(sync_on_output, 32'h7);
        repeat (12 * LINE) @(posedge clk_sys);
        check(coincidence, 32'h0);
        reg_write(`LLC_OFF_CTRL, 32'h00);
        reg_write(`LLC_OFF_REARM, 32'h00);
        n = 0;
        while (d[0] !== 1'b1 && n < 40) begin
            repeat (LINE) @(posedge clk_sys);
            reg_read(`LLC_OFF_STATUS);
            n++;
        end
        check({d[3], d[0]}, 32'h1);
        wait_sw(1'b1, 20 * LINE, n);
        check(calibration_path_switch, 32'h1);
        wait_sw(1'b0, 4 * LINE, n);
        check(n > LINE && n < 3 * LINE, 32'h1);
        reg_write(`LLC_OFF_CTRL, 32'h20);
        wait_sw(1'b1, 20 * LINE, n);
        check(n, 20 * LINE);
        reg_write(`LLC_OFF_CTRL, 32'h21);
        @(negedge csync_n_pin);
        repeat (12) @(posedge clk_sys);
        check(line_outs.line_x16_or_composite_sync_out, 32'h0);
        @(posedge csync_n_pin);
        repeat (12) @(posedge clk_sys);
        check(line_outs.line_x16_or_composite_sync_out, 32'h1);
        @(posedge clk_sys);
        active <= 1'b0;
        repeat (8 * LINE) @(posedge clk_sys);
        check(line_outs.line_x16_or_composite_sync_out, 32'h1);
        reg_read(`LLC_OFF_STATUS);
        check(d[1], 32'h0);
        n = sq_rises;
        repeat (4 * LINE) @(posedge clk_sys);
        check(sq_rises - n >= 3 && sq_rises - n <= 5, 32'h1);
        reg_write(`LLC_OFF_CTRL, 32'h20);
        @(posedge line_outs.line_rate_square_out);
        n = x16_rises;
        @(posedge line_outs.line_rate_square_out);
        check(x16_rises - n, 32'd16);
        active <= 1'b1;
        // a whole field, vertical interval included
        for (int i = 0; i < 10; i++) begin
            n = x16_rises;
            @(posedge line_outs.line_rate_square_out);
            check(x16_rises - n, 32'd16);
        end
        reg_write(`LLC_OFF_CTRL, 32'hA2);
        @(posedge clk_sys);
        #1 check(filter_switch_close, 32'h1);
        check(sync_on_output, 32'h2);
        end_of_test();
    end
endmodule : test_llc_line_lock
`default_nettype wire
